// file: src/mks_pkg.sv
// constants, register map and timing for the matrix key burst scanner
// assumes a single 100 MHz clock and a synchronous active-high reset
package mks_pkg;

  // ==========================================================================
  // matrix geometry
  localparam int          NUM_DRIVE = 8;
  localparam int          NUM_RECV  = 3;
  localparam int          NUM_KEYS  = NUM_DRIVE * NUM_RECV;
  localparam logic [4:0]  LAST_KEY  = 5'h17;
  localparam logic [4:0]  FIRST_KEY = 5'h00;

  // ==========================================================================
  // timing
  localparam int CLK_NS = 10;
  // eight selectable dwell times, in ns
  localparam int DWELL_NS [8] = '{125, 250, 500, 750, 1000, 1500, 2500, 4500};

  // least time, so round up to whole cycles, never below one
  function automatic logic [9:0] dwell_cycles(input logic [2:0] code);
    int c;
    c = (DWELL_NS[code] + CLK_NS - 1) / CLK_NS;
    if (c < 1) c = 1;
    return c[9:0];
  endfunction

  // burst length code 0..3 gives 16, 32, 48, 64 pulses
  localparam int PULSE_STEP = 16;
  function automatic logic [6:0] burst_pulses(input logic [1:0] code);
    return 7'(PULSE_STEP * (int'(code) + 1));
  endfunction

  // zero-crossing counter saturates here
  localparam logic [15:0] CONV_MAX = 16'hFFFF;

  // ==========================================================================
  // register map, byte addresses on a 9-bit bus
  localparam logic [8:0] ADDR_CTRL    = 9'h000;
  localparam logic [8:0] ADDR_STATUS  = 9'h004;
  localparam logic [1:0] REGION_KEY   = 2'h1;  // 0x080 + 4*key
  localparam logic [1:0] REGION_RES   = 2'h2;  // 0x100 + 4*key

  // ctrl fields
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_DWELL_LO = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_KEY_LO   = 8;
  localparam int STAT_CYC_LO   = 16;

  // key config fields
  localparam int KCFG_BL_LO   = 0;
  localparam int KCFG_INT_LO  = 8;
  localparam int KCFG_THR_LO  = 16;
  localparam logic [1:0] BL_RST  = 2'h0;
  localparam logic [7:0] INT_RST = 8'h02;
  localparam logic [7:0] THR_RST = 8'h0A;

  // ==========================================================================
  // sequencer states, gray along idle-seek-high-low-conv-done
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEEK = 3'b001,
    ST_HIGH = 3'b011,
    ST_LOW  = 3'b010,
    ST_CONV = 3'b110,
    ST_DONE = 3'b111
  } mks_state_t;

endpackage

// file: src/mks_ramp_sync.sv
// two-stage synchroniser for the ramp sense pins
// assumes the pins change asynchronously to clk_in
`timescale 1ns/1ps
`default_nettype none
module mks_ramp_sync (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [2:0] ramp_sense_in,
  output var  logic [2:0] ramp_sync_out
);

  // ==========================================================================
  // synchroniser
  logic [2:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_r        <= 3'h0;
      ramp_sync_out <= 3'h0;
    end else begin
      meta_r        <= ramp_sense_in;
      ramp_sync_out <= meta_r;
    end
  end

endmodule // mks_ramp_sync
`default_nettype wire

// file: src/mks_scanner.sv
// burst sequencer for a 24-key drive/receive matrix with avalon-mm registers
// assumes ramp sense pins are asynchronous and the receive lines are open drain
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] key number is eight times receive plus drive
// [R2] scan drive lines per receive line from zero
// [R3] each key uses its own burst length
// [R4] one burst finishes before the next starts
// [R5] convert after burst and pass result on
// [R6] keys with zero integrator setting are skipped
// [R7] clamp receive line on each falling drive edge
// [R8] after burst clamp and time zero crossing
// [R9] capture charge in dwell after each edge
// [R10] dwell selectable from eight settings
// [R11] host sets threshold below smallest touch swing
// [R12] keyscan cycle is one sample per enabled key
// [R13] crossing counter saturates then moves on
module mks_scanner
  import mks_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [8:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output var  logic [31:0] avs_readdata_out,
  output var  logic        avs_waitrequest_out,
  output var  logic [7:0]  drive_out,
  output var  logic [2:0]  recv_out,
  output var  logic [2:0]  recv_oe_out,
  input  wire logic [2:0]  ramp_sense_in,
  output var  logic        result_valid_out,
  output var  logic [4:0]  result_key_out,
  output var  logic [15:0] result_count_out
);

  // ==========================================================================
  // state
  mks_state_t  state_r, state_nxt;
  logic [4:0]  key_r, key_nxt;
  logic [9:0]  tmr_r, tmr_nxt;
  logic [6:0]  pulse_r, pulse_nxt;
  logic [6:0]  burst_r, burst_nxt;
  logic [9:0]  dwell_r, dwell_nxt;
  logic [15:0] conv_r, conv_nxt;
  logic [15:0] cycle_r, cycle_nxt;
  logic [31:0] ctrl_r;
  logic        wait_r;
  logic [2:0]  ramp_s;
  logic [1:0]  bl_mem   [NUM_KEYS];
  logic [7:0]  int_mem  [NUM_KEYS];
  logic [7:0]  thr_mem  [NUM_KEYS];
  logic [15:0] res_mem  [NUM_KEYS];

  mks_ramp_sync u_sync (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .ramp_sense_in (ramp_sense_in),
    .ramp_sync_out (ramp_s)
  );

  // ==========================================================================
  // sequencer decode
  wire        scan_en   = ctrl_r[CTRL_EN_BIT];
  wire [2:0]  dwell_cd  = ctrl_r[CTRL_DWELL_LO +: 3];
  wire        key_wrap  = (key_r == LAST_KEY);
  wire [4:0]  key_adv   = key_wrap ? FIRST_KEY : key_r + 5'h01;
  wire        key_on    = (int_mem[key_r] != 8'h00);
  wire        crossed   = ramp_s[key_r[4:3]];
  wire        conv_sat  = (conv_r == CONV_MAX);
  wire        conv_end  = (state_r == ST_CONV) && (crossed || conv_sat);
  wire        tmr_zero  = (tmr_r == 10'h000);

  // next-state logic, one key at a time
  always_comb begin
    state_nxt = state_r;
    key_nxt   = key_r;
    tmr_nxt   = tmr_r;
    pulse_nxt = pulse_r;
    burst_nxt = burst_r;
    dwell_nxt = dwell_r;
    conv_nxt  = conv_r;
    cycle_nxt = cycle_r;
    unique case (state_r)
      ST_IDLE: begin
        // [R2] scan starts at key zero
        if (scan_en) begin
          state_nxt = ST_SEEK;
          key_nxt   = FIRST_KEY;
        end
      end
      ST_SEEK: begin
        if (key_on) begin
          // [R3] burst length from key setup, dwell from the ctrl dwell code
          state_nxt = ST_HIGH;
          burst_nxt = burst_pulses(bl_mem[key_r]);
          dwell_nxt = dwell_cycles(dwell_cd);
          tmr_nxt   = dwell_cycles(dwell_cd) - 10'h001;
          pulse_nxt = 7'h00;
        end else begin
          // [R6] disabled key costs one cycle only
          key_nxt = key_adv;
          if (key_wrap) begin
            cycle_nxt = cycle_r + 16'h0001;
            if (!scan_en) state_nxt = ST_IDLE;
          end
        end
      end
      ST_HIGH: begin
        // [R9] dwell after rising edge
        if (tmr_zero) begin
          state_nxt = ST_LOW;
          tmr_nxt   = dwell_r - 10'h001;
          pulse_nxt = pulse_r + 7'h01;
        end else begin
          tmr_nxt = tmr_r - 10'h001;
        end
      end
      ST_LOW: begin
        if (!tmr_zero) begin
          tmr_nxt = tmr_r - 10'h001;
        end else if (pulse_r == burst_r) begin
          // [R4] burst complete before conversion
          state_nxt = ST_CONV;
          conv_nxt  = 16'h0000;
        end else begin
          state_nxt = ST_HIGH;
          tmr_nxt   = dwell_r - 10'h001;
        end
      end
      ST_CONV: begin
        // [R13] stop at saturation
        if (conv_end) state_nxt = ST_DONE;
        else          conv_nxt  = conv_r + 16'h0001;
      end
      ST_DONE: begin
        // [R12] wrap closes one keyscan cycle
        key_nxt   = key_adv;
        state_nxt = scan_en ? ST_SEEK : ST_IDLE;
        if (key_wrap) cycle_nxt = cycle_r + 16'h0001;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // [R1] key maps to one drive and one receive line
  wire [7:0] drive_nxt = (state_nxt == ST_HIGH) ? (8'h01 << key_nxt[2:0]) : 8'h00;
  // [R7] clamp on falling edge and [R8] during conversion
  wire       clamp_on  = (state_nxt == ST_LOW) || (state_nxt == ST_CONV);
  wire [2:0] clamp_nxt = clamp_on ? (3'h1 << key_nxt[4:3]) : 3'h0;

  // sequencer registers; pins come straight from flops
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r     <= ST_IDLE;
      key_r       <= FIRST_KEY;
      tmr_r       <= 10'h000;
      pulse_r     <= 7'h00;
      burst_r     <= 7'h00;
      dwell_r     <= 10'h000;
      conv_r      <= 16'h0000;
      cycle_r     <= 16'h0000;
      drive_out   <= 8'h00;
      recv_oe_out <= 3'h0;
      recv_out    <= 3'h0;
    end else begin
      state_r     <= state_nxt;
      key_r       <= key_nxt;
      tmr_r       <= tmr_nxt;
      pulse_r     <= pulse_nxt;
      burst_r     <= burst_nxt;
      dwell_r     <= dwell_nxt;
      conv_r      <= conv_nxt;
      cycle_r     <= cycle_nxt;
      drive_out   <= drive_nxt;
      recv_oe_out <= clamp_nxt;
      recv_out    <= 3'h0;   // clamp only ever pulls to ground
    end
  end

  // [R5] hand each result on as a one-cycle pulse
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      result_valid_out <= 1'b0;
      result_key_out   <= 5'h00;
      result_count_out <= 16'h0000;
    end else begin
      result_valid_out <= conv_end;
      if (conv_end) begin
        result_key_out   <= key_r;
        result_count_out <= conv_r;
      end
    end
  end

  // ==========================================================================
  // avalon-mm slave: one wait cycle, then the access completes
  wire        acc      = avs_read_in || avs_write_in;
  wire        wr_go    = avs_write_in && !wait_r;
  wire [1:0]  region   = avs_address_in[8:7];
  wire [4:0]  idx      = avs_address_in[6:2];
  wire        idx_ok   = (idx <= LAST_KEY);
  wire        hit_key  = (region == REGION_KEY) && idx_ok;
  wire        hit_res  = (region == REGION_RES) && idx_ok;
  wire [31:0] be_mask  = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                          {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  wire        busy     = (state_r != ST_IDLE);
  wire [31:0] stat_wd  = (32'(busy) << STAT_BUSY_BIT) | (32'(key_r) << STAT_KEY_LO)
                       | (32'(cycle_r) << STAT_CYC_LO);
  wire [31:0] kcfg_wd  = (32'(bl_mem[idx & {5{idx_ok}}]) << KCFG_BL_LO)
                       | (32'(int_mem[idx & {5{idx_ok}}]) << KCFG_INT_LO)
                       | (32'(thr_mem[idx & {5{idx_ok}}]) << KCFG_THR_LO);
  wire [31:0] res_wd   = {16'h0000, res_mem[idx & {5{idx_ok}}]};
  wire [31:0] kcfg_new = (kcfg_wd & ~be_mask) | (avs_writedata_in & be_mask);
  // unmapped reads return zero, unmapped writes are dropped
  wire [31:0] rd_word  = (avs_address_in == ADDR_CTRL)   ? ctrl_r  :
                         (avs_address_in == ADDR_STATUS) ? stat_wd :
                         hit_key ? kcfg_wd : hit_res ? res_wd : 32'h0000_0000;

  // handshake and control register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wait_r           <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
      ctrl_r           <= CTRL_RST;
    end else begin
      if (!wait_r) wait_r <= 1'b1;
      else if (acc) wait_r <= 1'b0;
      if (acc && wait_r) avs_readdata_out <= rd_word;
      // [R10] dwell code is three bits wide
      if (wr_go && avs_address_in == ADDR_CTRL) begin
        ctrl_r <= (ctrl_r & ~be_mask) | (avs_writedata_in & be_mask)
                & 32'h0000_0071;
      end
    end
  end

  assign avs_waitrequest_out = wait_r;

  // per-key setup and result storage
  for (genvar k = 0; k < NUM_KEYS; k++) begin : g_key
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        bl_mem[k]  <= BL_RST;
        int_mem[k] <= INT_RST;
        thr_mem[k] <= THR_RST;
        res_mem[k] <= 16'h0000;
      end else begin
        // [R11] threshold stored for the host's use
        if (wr_go && hit_key && idx == 5'(k)) begin
          bl_mem[k]  <= kcfg_new[KCFG_BL_LO +: 2];
          int_mem[k] <= kcfg_new[KCFG_INT_LO +: 8];
          thr_mem[k] <= kcfg_new[KCFG_THR_LO +: 8];
        end
        if (conv_end && key_r == 5'(k)) res_mem[k] <= conv_r;
      end
    end
  end

  // ==========================================================================
  // checks
  logic past_ok_r;
  always_ff @(posedge clk_in) begin
    if (rst_in) past_ok_r <= 1'b0;
    else        past_ok_r <= 1'b1;
  end

  property p_drive_map;
    @(posedge clk_in) disable iff (rst_in)
    state_r == ST_HIGH |-> drive_out == (8'h01 << key_r[2:0]) && recv_oe_out == 3'h0;
  endproperty
  a_drive_map: assert property (p_drive_map) else $error("drive line mismatch"); // [R1]

  property p_key_order;
    @(posedge clk_in) disable iff (rst_in || !past_ok_r)
    (key_r != $past(key_r) && $past(state_r) != ST_IDLE) |->
      key_r == (($past(key_r) == LAST_KEY) ? FIRST_KEY : $past(key_r) + 5'h01);
  endproperty
  a_key_order: assert property (p_key_order) else $error("key order broken"); // [R2]

  property p_burst_len;
    @(posedge clk_in) disable iff (rst_in)
    (state_r == ST_LOW && state_nxt == ST_CONV) |->
      pulse_r == burst_pulses(bl_mem[key_r]);
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst length wrong"); // [R3]

  property p_no_overlap;
    @(posedge clk_in) disable iff (rst_in)
    state_r inside {ST_CONV, ST_DONE, ST_SEEK, ST_IDLE} |-> drive_out == 8'h00;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("drive outside burst"); // [R4]

  property p_result;
    @(posedge clk_in) disable iff (rst_in)
    conv_end |=> result_valid_out && result_key_out == $past(key_r)
      && result_count_out == $past(conv_r) ##1 !result_valid_out;
  endproperty
  a_result: assert property (p_result) else $error("result not passed on"); // [R5]

  property p_skip;
    @(posedge clk_in) disable iff (rst_in)
    (state_r == ST_SEEK && int_mem[key_r] == 8'h00) |=> state_r != ST_HIGH;
  endproperty
  a_skip: assert property (p_skip) else $error("disabled key bursted"); // [R6]

  property p_clamp_low;
    @(posedge clk_in) disable iff (rst_in)
    state_r == ST_LOW |-> recv_oe_out == (3'h1 << key_r[4:3]) && drive_out == 8'h00;
  endproperty
  a_clamp_low: assert property (p_clamp_low) else $error("no clamp on fall"); // [R7]

  property p_conv_clamp;
    @(posedge clk_in) disable iff (rst_in)
    (state_r == ST_CONV && !conv_end) |=> state_r == ST_CONV && conv_r == $past(conv_r) + 16'h0001
      && recv_oe_out == (3'h1 << key_r[4:3]);
  endproperty
  a_conv_clamp: assert property (p_conv_clamp) else $error("conversion not timed"); // [R8]

  property p_dwell;
    @(posedge clk_in) disable iff (rst_in)
    (state_r == ST_SEEK && state_nxt == ST_HIGH && dwell_cd == 3'h0) |=>
      state_r == ST_HIGH [*8] ##1 state_r == ST_HIGH [*5]
      ##1 state_r == ST_LOW;
  endproperty
  a_dwell: assert property (p_dwell) else $error("dwell length wrong"); // [R9]

  property p_cycle;
    @(posedge clk_in) disable iff (rst_in || !past_ok_r)
    ($past(key_r) == LAST_KEY && key_r == FIRST_KEY && $past(state_r) != ST_IDLE) |->
      cycle_r == $past(cycle_r) + 16'h0001;
  endproperty
  a_cycle: assert property (p_cycle) else $error("keyscan cycle not counted"); // [R12]

  property p_sat;
    @(posedge clk_in) disable iff (rst_in)
    (state_r == ST_CONV && conv_sat) |=> state_r == ST_DONE ##1 state_r != ST_CONV;
  endproperty
  a_sat: assert property (p_sat) else $error("counter not saturated"); // [R13]

endmodule // mks_scanner
`default_nettype wire

// file: sim/mks_matrix_model.sv
// electrode matrix model: sample capacitors ramp back to zero after a burst
// assumes one drive line high at a time and open-drain clamps on receive lines
`timescale 1ns/1ps
`default_nettype none
module mks_matrix_model #(
  parameter int LEAD = 13  // clamp cycles of a low dwell before the ramp counts
) (
  input  wire logic       clk_in,
  input  wire logic [7:0] drive_in,
  input  wire logic [2:0] recv_in,
  input  wire logic [2:0] recv_oe_in,
  input  wire logic       stuck_in,  // bench order: ramp never crosses
  output var  logic [2:0] ramp_sense_out
);
  logic [2:0]  drv_idx_r = 3'h0;
  logic [15:0] run_r [3] = '{default: 16'h0000};
  logic [2:0]  ramp_r = 3'h0;

  // ==========
  // crossing delay grows with key number, so results differ per key
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 8; i++) begin
      if (drive_in[i] === 1'b1) drv_idx_r <= 3'(i);
    end
    for (int y = 0; y < 3; y++) begin
      // a clamp counts only while pulled to ground and no drive line is high
      run_r[y] <= (recv_oe_in[y] && !recv_in[y] && drive_in == 8'h00) ? run_r[y] + 16'h0001
                                                                      : 16'h0000;
      ramp_r[y] <= !stuck_in && (run_r[y] >= 16'(LEAD + 20 + 3 * (8 * y + drv_idx_r)));
    end
  end
  assign ramp_sense_out = ramp_r;
endmodule // mks_matrix_model
`default_nettype wire

// file: sim/mks_scanner_test.sv
// self-checking bench for the matrix key burst scanner
// assumes the scanner, its package and the matrix model are compiled first
`timescale 1ns/1ps
`default_nettype none
module mks_scanner_test
  import mks_pkg::*;
;
  typedef struct {logic [4:0] pin_key; logic [4:0] key; logic [15:0] cnt; int pulses;} mks_res_t;
  typedef struct {logic [4:0] key; logic [1:0] bl; logic [7:0] integ; int pulses;} mks_row_t;

  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [8:0]  avs_address_in = 9'h000;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic [7:0]  drive_out;
  logic [2:0]  recv_out;
  logic [2:0]  recv_oe_out;
  logic [2:0]  ramp_sense;
  logic        result_valid_out;
  logic [4:0]  result_key_out;
  logic [15:0] result_count_out;
  logic        stuck = 1'b0;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  mks_res_t    res_q [$];
  int          pulse_n = 0;
  logic [7:0]  drv_prev = 8'h00;
  logic [7:0]  drv_pat = 8'h01;
  logic [2:0]  clamp_line = 3'b001;
  // inputs beside the pulse count each key should give
  mks_row_t    rows [8] = '{'{5'h00, 2'h1, 8'h02, 32}, '{5'h01, 2'h0, 8'h00, 0},
                            '{5'h07, 2'h3, 8'h02, 64}, '{5'h08, 2'h0, 8'h00, 0},
                            '{5'h0F, 2'h2, 8'h02, 48}, '{5'h10, 2'h0, 8'h00, 0},
                            '{5'h16, 2'h0, 8'h00, 0}, '{5'h17, 2'h0, 8'h05, 16}};

  mks_scanner dut (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hF),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .drive_out(drive_out), .recv_out(recv_out), .recv_oe_out(recv_oe_out),
    .ramp_sense_in(ramp_sense), .result_valid_out(result_valid_out),
    .result_key_out(result_key_out), .result_count_out(result_count_out));
  mks_matrix_model model (.clk_in(clk_in), .drive_in(drive_out), .recv_in(recv_out),
    .recv_oe_in(recv_oe_out), .stuck_in(stuck), .ramp_sense_out(ramp_sense));

  // ==========
  // clock and watchdog; the ceiling covers one saturated conversion
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 95000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("FAIL %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask

  task automatic finish_test();
    if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========
  // avalon master: hold the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= wd;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask

  task automatic rd_check(input logic [8:0] a, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    check(what, rd, exp);
  endtask

  task automatic reset_dut();
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
  endtask

  task automatic wait_res(input int n);
    while (res_q.size() < n) @(posedge clk_in);
  endtask

  // ==========
  // pin monitor: pulses, drive line and clamp line of each burst
  always @(posedge clk_in) begin
    drv_prev <= drive_out;
    if (rst_in) pulse_n <= 0;
    else begin
      if (drive_out != 8'h00 && drv_prev == 8'h00) begin
        check("single drive line", 32'($onehot(drive_out)), 1);
        if (pulse_n > 0) check("same drive line", drive_out, drv_pat);
        drv_pat <= drive_out;
        pulse_n <= pulse_n + 1;
      end
      if (drive_out == 8'h00 && drv_prev != 8'h00) begin
        check("clamp at falling edge", 32'($onehot(recv_oe_out)), 1);
        check("clamp pulls low", 32'(recv_out), 32'h0);
        clamp_line <= recv_oe_out;
      end
      if (result_valid_out === 1'b1) begin
        res_q.push_back('{5'(8 * $clog2(clamp_line) + $clog2(drv_pat)), result_key_out,
                          result_count_out, pulse_n});
        pulse_n <= 0;
      end
    end
  end

  // ==========
  // main sequence
  initial begin
    int n;
    int exp_p [24];
    logic [4:0] ek [$];
    logic [31:0] d;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    check("quiet after reset", 32'({drive_out, recv_oe_out, recv_out, result_valid_out,
                                    avs_waitrequest_out}), 32'h1);
    rd_check(ADDR_CTRL, CTRL_RST, "ctrl reset");
    rd_check(9'h084, {8'h00, THR_RST, INT_RST, 6'h00, BL_RST}, "keycfg reset");
    rd_check(ADDR_STATUS, 32'h0, "status reset");
    rd_check(9'h1FC, 32'h0, "unmapped read");
    // every dwell code: measure first pulse, then abort by reset mid-burst
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CTRL, 32'((c << 4) | 1));
      while (drive_out === 8'h00) @(posedge clk_in);
      n = 0;
      while (drive_out !== 8'h00) begin
        n++;
        @(posedge clk_in);
      end
      check("dwell high", n, (DWELL_NS[c] + 9) / 10);
      n = 0;
      while (drive_out === 8'h00 && recv_oe_out === 3'b001) begin
        n++;
        @(posedge clk_in);
      end
      check("dwell clamp", n, (DWELL_NS[c] + 9) / 10);
      reset_dut();
    end
    // table scan: per-key burst length and disabled keys over one keyscan cycle
    for (int k = 0; k < 24; k++) exp_p[k] = 16;
    foreach (rows[i]) begin
      wr(9'h080 + 9'(4 * rows[i].key), {8'h00, 8'h0A, rows[i].integ, 6'h00, rows[i].bl});
      exp_p[rows[i].key] = rows[i].pulses;
    end
    res_q.delete();
    wr(ADDR_CTRL, 32'h0000_0001);
    for (int k = 0; k < 24; k++) if (exp_p[k] != 0) ek.push_back(5'(k));
    wait_res(ek.size());
    foreach (ek[i]) begin
      check("result key order", res_q[i].key, ek[i]);
      check("key from pins", res_q[i].pin_key, ek[i]);
      check("burst pulses", res_q[i].pulses, exp_p[ek[i]]);
      if (i > 0) begin
        d = 32'(res_q[i].cnt) - 32'(res_q[i - 1].cnt);
        check("count step", d, 32'(3 * (ek[i] - ek[i - 1])));
      end
    end
    rd_check(9'h15C, 32'(res_q[ek.size() - 1].cnt), "result register");
    // lone key whose ramp never crosses, then recovers
    reset_dut();
    stuck <= 1'b1;
    for (int k = 0; k < 24; k++) wr(9'h080 + 9'(4 * k), (k == 9) ? 32'h000A_0200 : 32'h0);
    res_q.delete();
    wr(ADDR_CTRL, 32'h0000_0001);
    wait_res(1);
    check("saturated count", res_q[0].cnt, 16'hFFFF);
    check("only enabled key", res_q[0].key, 5'h09);
    stuck <= 1'b0;
    wait_res(2);
    check("scan goes on", res_q[1].key, 5'h09);
    check("count recovered", 32'(res_q[1].cnt != 16'hFFFF), 1);
    finish_test();
  end
endmodule // mks_scanner_test
`default_nettype wire
